//--- verilog/load_switch_defs.vh
/*
 * Offsets, field positions, reset defaults and timing counts for the
 * load switch and option register pair.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef LOAD_SWITCH_DEFS_VH
`define LOAD_SWITCH_DEFS_VH

// register offsets on the 8-bit register port
`define LOAD_SWITCH_CONTROL_ADDR 8'h62
`define MISC_OPTION_CONTROL_ADDR 8'h63

// load_switch_control fields
`define MODE_LSB 0
`define MODE_MSB 1
`define CURRENT_LIMIT_SELECT_LSB 2
`define CURRENT_LIMIT_SELECT_MSB 3

// switch modes
`define MODE_OFF 2'h0
`define MODE_FORCED_ON 2'h1
`define MODE_BYPASS_AUTO 2'h2
`define MODE_BYPASS_ON 2'h3

// current-limit codes
`define CURRENT_LIMIT_SELECT_100MA 2'h0
`define CURRENT_LIMIT_SELECT_500MA 2'h1
`define CURRENT_LIMIT_SELECT_750MA 2'h2
`define CURRENT_LIMIT_SELECT_2500MA 2'h3

// misc_option_control fields
`define OPT_DRAIN_BIT 0
`define OPT_SKIP_SLEW_BIT 1
`define OPT_NO_DELAY_BIT 2
`define OPT_OSC_GATE_BIT 3
`define OPT_SPARE_LSB 4
`define OPT_SPARE_MSB 7

// reset fallbacks before the one-time-programmable defaults are caught
`define LOAD_SWITCH_RESET 8'h00
`define MISC_OPTION_RESET 8'h00

// slow clock: 32 kHz tick from the 50 MHz clock
`define CLK_FREQ_HZ 50000000
`define SLOW_CLK_HZ 32768
`define SLOW_TICK_CYCLES (`CLK_FREQ_HZ / `SLOW_CLK_HZ)

`endif

//--- verilog/tick_divider.v
/*
 * Free-running divider that gives a one-cycle enable pulse every
 * PERIOD clock cycles.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module tick_divider #(
   parameter integer PERIOD = 1526,
   parameter integer WIDTH = 11
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // enable pulse
   output reg tick_ff
);
   reg [WIDTH-1:0] count_ff;
   localparam integer LAST_INT = PERIOD - 1;
   localparam [WIDTH-1:0] LAST = LAST_INT[WIDTH-1:0];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= {WIDTH{1'b0}};
         tick_ff <= 1'b0;
      end else if (count_ff == LAST) begin
         count_ff <= {WIDTH{1'b0}};
         tick_ff <= 1'b1;
      end else begin
         count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
         tick_ff <= 1'b0;
      end
   end
endmodule

//--- verilog/load_switch_and_option_regs.v
/*
 * Load switch control register and miscellaneous option register, with
 * the switch, slow-clock pin, buck-four slew and select-delay, and fast
 * oscillator gating logic they steer.
 * Assumes a simple 8-bit register port (address, write strobe, read data
 * one cycle later), all inputs synchronous to clk, and that rst is the
 * power-on reset. One-time-programmable defaults arrive as static inputs.
 */
`timescale 1ns/1ps
`include "load_switch_defs.vh"

// How it works
// - mode 00 turns the switch off; mode 01 holds it on.
// - mode 10 is bypass, switched on by the buck-four comparator.
// - mode 11 is bypass held on.
// - in bypass, overvoltage blocks forced PWM and clears mode to 00.
// - current-limit code picks 100 mA, 500 mA, 750 mA or 2.5 A.
// - power-on reset reinitialises both registers.
// - reserved switch register bits always read zero.
// - drain option clear gives push-pull slow clock, set gives open drain.
// - skip-slew clear moves buck-four voltage at step-time rate.
// - skip-slew set applies new buck-four voltage at once.
// - delay option clear delays lowering select change 0.5-1 slow periods.
// - gating bit clear keeps the fast oscillator always running.
// - gating bit set stops oscillator only when both request pins low.
module load_switch_and_option_regs #(
   parameter integer SLOW_TICK = `SLOW_TICK_CYCLES,
   parameter integer VOLT_WIDTH = 7,
   parameter integer STEP_WIDTH = 3
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port
   input wire [7:0] regAddr,
   input wire regWrite,
   input wire [7:0] regWrData,
   output reg [7:0] regRdData_ff,
   // reset-time defaults
   input wire switchEnablePinHigh,
   input wire switchEnablePinLow,
   input wire [1:0] otpCurrentLimit,
   input wire [7:0] otpOptions,
   // buck converter four status and control
   input wire buck4OnComparator,
   input wire buck4OutputOver,
   input wire buck4ForcePwmReq,
   input wire [VOLT_WIDTH-1:0] buck4TargetVoltage,
   input wire [STEP_WIDTH-1:0] slewStepTime,
   input wire buck4VoltageSelectPin,
   // request pins
   input wire powerRequestPin,
   input wire clockRequestPin,
   // slow clock source
   input wire slowClockIn,
   // switch outputs
   output reg switchOn_ff,
   output reg bypassMode_ff,
   output reg [1:0] currentLimitSelect_ff,
   output reg buck4ForcePwm_ff,
   // buck converter four voltage
   output reg [VOLT_WIDTH-1:0] buck4AppliedVoltage_ff,
   output reg buck4SelectApplied_ff,
   // slow clock pin
   output reg slowClockOut_ff,
   output reg slowClockOe_ff,
   // fast oscillator
   output reg fastOscEnable_ff
);
   reg [1:0] mode_ff;
   reg [1:0] current_limit_select_ff;
   reg [3:0] opt_ff;
   reg [3:0] spare_ff;
   reg strapPending_ff;
   reg [1:0] nxt_mode;
   reg [STEP_WIDTH:0] stepCount_ff;
   reg [1:0] selDelay_ff;
   reg selPending_ff;
   wire slowTick;
   wire halfTick;
   wire overTrip;
   wire stepDone;

   tick_divider #(
      .PERIOD(SLOW_TICK),
      .WIDTH(16)
   ) u_slow_tick (
      .clk(clk),
      .rst(rst),
      .tick_ff(slowTick)
   );

   // half-period tick keeps the select delay inside its window
   tick_divider #(
      .PERIOD(SLOW_TICK / 2),
      .WIDTH(16)
   ) u_half_tick (
      .clk(clk),
      .rst(rst),
      .tick_ff(halfTick)
   );

   // trip only counts while a bypass mode is selected
   assign overTrip = buck4OutputOver && mode_ff[`MODE_MSB];

   always @* begin
      nxt_mode = mode_ff;
      if (regWrite && regAddr == `LOAD_SWITCH_CONTROL_ADDR) begin
         nxt_mode = regWrData[`MODE_MSB:`MODE_LSB];
      end
      // hardware clear wins over a same-cycle software write
      if (overTrip) begin
         nxt_mode = `MODE_OFF;
      end
   end

   // registers; pin strap caught on the first clocked edge after release
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_ff <= `MODE_OFF;
         current_limit_select_ff <= 2'h0;
         opt_ff <= 4'h0;
         spare_ff <= 4'h0;
         strapPending_ff <= 1'b1;
      end else if (strapPending_ff) begin
         mode_ff <= {switchEnablePinHigh, switchEnablePinLow};
         current_limit_select_ff <= otpCurrentLimit;
         opt_ff <= otpOptions[3:0];
         spare_ff <= otpOptions[`OPT_SPARE_MSB:`OPT_SPARE_LSB];
         strapPending_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         if (regWrite && regAddr == `LOAD_SWITCH_CONTROL_ADDR) begin
            current_limit_select_ff <= regWrData[`CURRENT_LIMIT_SELECT_MSB:`CURRENT_LIMIT_SELECT_LSB];
         end
         if (regWrite && regAddr == `MISC_OPTION_CONTROL_ADDR) begin
            opt_ff <= regWrData[3:0];
            spare_ff <= regWrData[`OPT_SPARE_MSB:`OPT_SPARE_LSB];
         end
      end
   end

   // read port; unmapped addresses read zero
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData_ff <= 8'h00;
      end else if (regAddr == `LOAD_SWITCH_CONTROL_ADDR) begin
         regRdData_ff <= {4'h0, current_limit_select_ff, mode_ff};
      end else if (regAddr == `MISC_OPTION_CONTROL_ADDR) begin
         regRdData_ff <= {spare_ff, opt_ff};
      end else begin
         regRdData_ff <= 8'h00;
      end
   end

   // switch drive
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         switchOn_ff <= 1'b0;
         bypassMode_ff <= 1'b0;
         currentLimitSelect_ff <= `CURRENT_LIMIT_SELECT_100MA;
         buck4ForcePwm_ff <= 1'b0;
      end else begin
         case (mode_ff)
            `MODE_OFF: switchOn_ff <= 1'b0;
            `MODE_FORCED_ON: switchOn_ff <= 1'b1;
            `MODE_BYPASS_AUTO: switchOn_ff <= buck4OnComparator && !overTrip;
            `MODE_BYPASS_ON: switchOn_ff <= !overTrip;
            default: switchOn_ff <= 1'b0;
         endcase
         bypassMode_ff <= mode_ff[`MODE_MSB] && !overTrip;
         currentLimitSelect_ff <= current_limit_select_ff;
         buck4ForcePwm_ff <= buck4ForcePwmReq && !overTrip;
      end
   end

   // step interval: step-time plus one slow ticks per voltage step
   assign stepDone = (stepCount_ff == {(STEP_WIDTH+1){1'b0}});

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         buck4AppliedVoltage_ff <= {VOLT_WIDTH{1'b0}};
         stepCount_ff <= {(STEP_WIDTH+1){1'b0}};
      end else if (opt_ff[`OPT_SKIP_SLEW_BIT]) begin
         buck4AppliedVoltage_ff <= buck4TargetVoltage;
         stepCount_ff <= {(STEP_WIDTH+1){1'b0}};
      end else if (slowTick) begin
         if (!stepDone) begin
            stepCount_ff <= stepCount_ff - {{STEP_WIDTH{1'b0}}, 1'b1};
         end else if (buck4AppliedVoltage_ff != buck4TargetVoltage) begin
            // one code per interval; rate set by the step-time field
            if (buck4AppliedVoltage_ff < buck4TargetVoltage) begin
               buck4AppliedVoltage_ff <= buck4AppliedVoltage_ff + 1'b1;
            end else begin
               buck4AppliedVoltage_ff <= buck4AppliedVoltage_ff - 1'b1;
            end
            stepCount_ff <= {1'b0, slewStepTime};
         end
      end
   end

   // select pin: a falling request waits for the second half-period tick,
   // so the delay lands between half and one slow period
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         buck4SelectApplied_ff <= 1'b0;
         selDelay_ff <= 2'h0;
         selPending_ff <= 1'b0;
      end else if (buck4VoltageSelectPin || opt_ff[`OPT_NO_DELAY_BIT]) begin
         buck4SelectApplied_ff <= buck4VoltageSelectPin;
         selPending_ff <= 1'b0;
         selDelay_ff <= 2'h0;
      end else if (buck4SelectApplied_ff && !selPending_ff) begin
         selPending_ff <= 1'b1;
         selDelay_ff <= 2'h0;
      end else if (selPending_ff && halfTick) begin
         if (selDelay_ff == 2'h1) begin
            buck4SelectApplied_ff <= 1'b0;
            selPending_ff <= 1'b0;
         end
         selDelay_ff <= selDelay_ff + 2'h1;
      end
   end

   // slow clock pin and fast oscillator
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         slowClockOut_ff <= 1'b0;
         slowClockOe_ff <= 1'b0;
         fastOscEnable_ff <= 1'b1;
      end else begin
         if (opt_ff[`OPT_DRAIN_BIT]) begin
            slowClockOut_ff <= 1'b0;
            slowClockOe_ff <= !slowClockIn;
         end else begin
            slowClockOut_ff <= slowClockIn;
            slowClockOe_ff <= 1'b1;
         end
         if (!opt_ff[`OPT_OSC_GATE_BIT]) begin
            fastOscEnable_ff <= 1'b1;
         end else begin
            fastOscEnable_ff <= powerRequestPin || clockRequestPin;
         end
      end
   end
endmodule

//--- sim/load_switch_regs_properties.sv
/*
 * Concurrent checks on the load switch and option register block.
 * Assumes it is bound to the block's top module and sees its ports only.
 */
`timescale 1ns/1ps
module load_switch_regs_checker (
   // clock and reset
   input wire clk,
   input wire rst,
   // register port
   input wire [7:0] regAddr,
   input wire regWrite,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData_ff,
   // inputs watched
   input wire buck4OutputOver,
   input wire powerRequestPin,
   input wire clockRequestPin,
   input wire slowClockIn,
   // outputs watched
   input wire switchOn_ff,
   input wire bypassMode_ff,
   input wire [1:0] currentLimitSelect_ff,
   input wire buck4ForcePwm_ff,
   input wire slowClockOut_ff,
   input wire slowClockOe_ff,
   input wire fastOscEnable_ff
);
   reg [1:0] upCnt_ff;
   wire live;
   // defaults land on the first edge after reset, so checks wait it out
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         upCnt_ff <= 2'h0;
      end else if (upCnt_ff != 2'h3) begin
         upCnt_ff <= upCnt_ff + 2'h1;
      end
   end
   assign live = (upCnt_ff == 2'h3);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence wrSwitch;
      live && regWrite && regAddr == 8'h62 && !buck4OutputOver;
   endsequence
   sequence wrOption;
      live && regWrite && regAddr == 8'h63;
   endsequence
   osc_request_run_a: assert property ((powerRequestPin || clockRequestPin) |=> fastOscEnable_ff)
      else $error("oscillator stopped with a request pin high");
   clk_drive_a: assert property (live && slowClockOe_ff |-> slowClockOut_ff == $past(slowClockIn))
      else $error("driven slow clock level wrong");
   clk_release_a: assert property (live && !slowClockOe_ff |-> !slowClockOut_ff && $past(slowClockIn))
      else $error("slow clock released at the wrong time");
   reserved_zero_a: assert property (regAddr == 8'h62 |=> regRdData_ff[7:4] == 4'h0)
      else $error("reserved switch bits read nonzero");
   option_readback_a: assert property (wrOption ##1 (regAddr == 8'h63 && !regWrite)
      |=> regRdData_ff == $past(regWrData, 2))
      else $error("option register readback wrong");
   limit_apply_a: assert property (wrSwitch |-> ##2 currentLimitSelect_ff == $past(regWrData[3:2], 2))
      else $error("current limit not applied");
   mode_off_a: assert property ((wrSwitch and regWrData[1:0] == 2'h0)
      |-> ##2 !switchOn_ff && !bypassMode_ff)
      else $error("switch not off in mode 00");
   mode_forced_a: assert property ((wrSwitch and regWrData[1:0] == 2'h1)
      |-> ##2 switchOn_ff && !bypassMode_ff)
      else $error("switch not forced on in mode 01");
   bypass_held_a: assert property ((wrSwitch and regWrData[1:0] == 2'h3) ##1 !buck4OutputOver
      |=> switchOn_ff && bypassMode_ff)
      else $error("bypass not held on in mode 11");
   over_trip_a: assert property (live && bypassMode_ff && buck4OutputOver && !$past(regWrite)
      |=> !bypassMode_ff && !switchOn_ff && !buck4ForcePwm_ff)
      else $error("overvoltage did not open the bypass switch");
endmodule
bind load_switch_and_option_regs load_switch_regs_checker i_checker (
   .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
   .regRdData_ff(regRdData_ff), .buck4OutputOver(buck4OutputOver),
   .powerRequestPin(powerRequestPin), .clockRequestPin(clockRequestPin),
   .slowClockIn(slowClockIn), .switchOn_ff(switchOn_ff), .bypassMode_ff(bypassMode_ff),
   .currentLimitSelect_ff(currentLimitSelect_ff), .buck4ForcePwm_ff(buck4ForcePwm_ff),
   .slowClockOut_ff(slowClockOut_ff), .slowClockOe_ff(slowClockOe_ff),
   .fastOscEnable_ff(fastOscEnable_ff)
);

//--- sim/tb_top.sv
/*
 * Self-checking bench for the load switch and option registers.
 * Assumes the block's register port: write strobe, read data one edge later.
 */
`timescale 1ns/1ps
module tb_top;
   localparam integer TICK = 4;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] regAddr = 8'h00;
   reg regWrite = 1'b0;
   reg [7:0] regWrData = 8'h00;
   reg pinHigh = 1'b1;
   reg pinLow = 1'b0;
   reg [1:0] otpLimit = 2'h3;
   reg [7:0] otpOpts = 8'ha5;
   reg onComp = 1'b0;
   reg overV = 1'b0;
   reg pwmReq = 1'b1;
   reg [6:0] target = 7'h00;
   reg [2:0] stepTime = 3'h0;
   reg selPin = 1'b1;
   reg pwrReq = 1'b0;
   reg clkReq = 1'b0;
   reg slowIn = 1'b0;
   wire [7:0] rdData;
   wire switchOn, bypassMode, forcePwm, selApplied, clkOut, clkOe, oscOn;
   wire [1:0] limitOut;
   wire [6:0] appliedVolt;
   integer error_cnt = 0;
   integer num_checks = 0;
   integer cycCnt = 0;
   integer i;
   load_switch_and_option_regs #(.SLOW_TICK(TICK)) i_dut (
      .clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
      .regRdData_ff(rdData), .switchEnablePinHigh(pinHigh), .switchEnablePinLow(pinLow),
      .otpCurrentLimit(otpLimit), .otpOptions(otpOpts), .buck4OnComparator(onComp),
      .buck4OutputOver(overV), .buck4ForcePwmReq(pwmReq), .buck4TargetVoltage(target),
      .slewStepTime(stepTime), .buck4VoltageSelectPin(selPin), .powerRequestPin(pwrReq),
      .clockRequestPin(clkReq), .slowClockIn(slowIn), .switchOn_ff(switchOn),
      .bypassMode_ff(bypassMode), .currentLimitSelect_ff(limitOut), .buck4ForcePwm_ff(forcePwm),
      .buck4AppliedVoltage_ff(appliedVolt), .buck4SelectApplied_ff(selApplied),
      .slowClockOut_ff(clkOut), .slowClockOe_ff(clkOe), .fastOscEnable_ff(oscOn));
   always #10 clk = ~clk;
   task summarize;
      begin
         $display("checks=%0d errors=%0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
         end else begin
            $display("CHECKS NOT OK");
         end
         $finish;
      end
   endtask
   // slow clock toggles off the edge; a hang ends the run as a mismatch
   always @(posedge clk) begin
      cycCnt <= cycCnt + 1;
      if (cycCnt[2:0] == 3'h7) begin
         slowIn <= #1 ~slowIn;
      end
      if (cycCnt == 3000) begin
         error_cnt = error_cnt + 1;
         summarize;
      end
   end
   task chk(input [7:0] got, input [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task step(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         step(1);
         regAddr = a;
         regWrData = d;
         regWrite = 1'b1;
         step(1);
         regWrite = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
      begin
         step(1);
         regAddr = a;
         step(1);
         chk(rdData, exp);
      end
   endtask
   initial begin
      step(6);
      rst = 1'b0;
      rd(8'h62, 8'h0e);
      rd(8'h63, 8'ha5);
      chk({6'h0, bypassMode, switchOn}, 8'h02);
      onComp = 1'b1;
      step(2);
      chk({7'h0, switchOn}, 8'h01);
      for (i = 0; i < 16; i = i + 1) begin
         wr(8'h62, {4'hf, i[3:0]});
         rd(8'h62, {4'h0, i[3:0]});
         chk({6'h0, limitOut}, {6'h0, i[3:2]});
         chk({6'h0, bypassMode, switchOn}, {6'h0, i[1], i[1:0] != 2'h0});
      end
      wr(8'h62, 8'h01);
      overV = 1'b1;
      rd(8'h62, 8'h01);
      wr(8'h62, 8'h03);
      step(1);
      chk({5'h0, forcePwm, bypassMode, switchOn}, 8'h00);
      rd(8'h62, 8'h00);
      overV = 1'b0;
      chk({6'h0, forcePwm, switchOn}, 8'h02);
      wr(8'h62, 8'h02);
      step(1);
      chk({6'h0, bypassMode, switchOn}, 8'h03);
      overV = 1'b1;
      step(1);
      chk({5'h0, forcePwm, bypassMode, switchOn}, 8'h00);
      rd(8'h62, 8'h00);
      overV = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h63, {4'h0, i[2], 3'h0});
         pwrReq = i[1];
         clkReq = i[0];
         step(2);
         chk({7'h0, oscOn}, {7'h0, !i[2] || i[1:0] != 2'h0});
         chk({7'h0, clkOe}, 8'h01);
      end
      wr(8'h63, 8'h02);
      target = 7'h55;
      step(2);
      chk({1'b0, appliedVolt}, 8'h55);
      wr(8'h63, 8'h00);
      target = 7'h57;
      step(2);
      chk({7'h0, appliedVolt == 7'h57}, 8'h00);
      step(10 * TICK);
      chk({1'b0, appliedVolt}, 8'h57);
      stepTime = 3'h1;
      target = 7'h59;
      step(2 * TICK);
      chk({7'h0, appliedVolt == 7'h59}, 8'h00);
      step(2 * TICK);
      chk({1'b0, appliedVolt}, 8'h59);
      selPin = 1'b0;
      step(2);
      chk({7'h0, selApplied}, 8'h01);
      step(3 * TICK);
      chk({7'h0, selApplied}, 8'h00);
      wr(8'h63, 8'h04);
      selPin = 1'b1;
      step(2);
      selPin = 1'b0;
      step(2);
      chk({7'h0, selApplied}, 8'h00);
      rst = 1'b1;
      pinHigh = 1'b0;
      pinLow = 1'b1;
      otpLimit = 2'h0;
      otpOpts = 8'h5a;
      step(2);
      rst = 1'b0;
      rd(8'h62, 8'h01);
      rd(8'h63, 8'h5a);
      summarize;
   end
endmodule
